/* File: shared/silc_pkg.sv */
// Package with constants and types for the status input logger channel.
package silc_pkg;

  // Datapoint and threshold width; time-on values up to the log period fit.
  localparam int          DP_W            = 16;
  // Clock rate and the one-second tick count derived from it.
  localparam int          CLK_HZ          = 25000000;
  localparam int          SEC_CYCLES      = CLK_HZ;
  // Default log period in seconds.
  localparam logic [15:0] LOG_PERIOD_DEF  = 16'h012c;
  // Debounce time in microseconds and its cycle count.
  localparam int          DEB_US          = 1000;
  localparam int          DEB_CYCLES      = (DEB_US * (CLK_HZ / 1000000));
  // Reset values of the datapoint and accumulator.
  localparam logic [15:0] DP_RST          = 16'h0000;
  // Number of pulse input pins on the connector.
  localparam int          NUM_PINS        = 2;
  // Depth of the datapoint FIFO.
  localparam int          FIFO_DEPTH      = 4;

  // Logging modes of the channel.
  typedef enum logic [1:0]
  {
    SILC_SPOT     = 2'b00,
    SILC_SPOT_INV = 2'b01,
    SILC_TON      = 2'b10,
    SILC_TON_INV  = 2'b11
  } silc_mode_t;

  // Trigger comparison kinds.
  typedef enum logic [1:0]
  {
    SILC_TRG_OFF     = 2'b00,
    SILC_TRG_ABOVE   = 2'b01,
    SILC_TRG_BELOW   = 2'b10,
    SILC_TRG_BETWEEN = 2'b11
  } silc_trg_t;

  // One logged datapoint as it travels to the FIFO.
  typedef struct packed
  {
    logic            trig;
    logic [DP_W-1:0] value;
  } silc_dp_t;

  // Trigger configuration.
  typedef struct packed
  {
    silc_trg_t       kind;
    logic [DP_W-1:0] thr_a;
    logic [DP_W-1:0] thr_b;
  } silc_trg_cfg_t;

endpackage : silc_pkg

/* File: src/silc_debounce.sv */
// Input debouncer: two-stage synchroniser followed by a stability counter.
module silc_debounce #(
  parameter int CYCLES = silc_pkg::DEB_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Raw and filtered level
  input  wire logic din,
  output logic      dout
);

  localparam int CW = $clog2(CYCLES + 1);

  logic          sync1_reg;
  logic          sync2_reg;
  logic [CW-1:0] cnt_reg;

  // Synchroniser; only the second stage is looked at.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= din;
      sync2_reg <= sync1_reg;
    end
  end

  // Output follows only after the level holds for the full count.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_reg <= '0;
      dout    <= 1'b0;
    end
    else if (sync2_reg == dout)
    begin
      cnt_reg <= '0;
    end
    else if (cnt_reg == CW'(CYCLES - 1))
    begin
      cnt_reg <= '0;
      dout    <= sync2_reg;
    end
    else
    begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Output changes only after CYCLES differing samples.
  a_deb_hold : assert property (@(posedge clk) disable iff (!rst_b) // [R15]
    $changed(dout) |-> $past(cnt_reg) == CW'(CYCLES - 1))
    else $error("Debounced level changed before the hold count.");

endmodule : silc_debounce

/* File: src/silc_fifo.sv */
// Small FIFO with valid and ready on both sides.
module silc_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = silc_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_b,
  // Write side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Read side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wp_reg;
  logic [AW-1:0]    rp_reg;
  logic [AW:0]      cnt_reg;
  logic             wr;
  logic             rd;

  // Handshakes and honest flags.
  assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem_reg[rp_reg];
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;

  // Storage written at the write index.
  always_ff @(posedge clk)
  begin
    if (wr)
    begin
      mem_reg[wp_reg] <= in_data;
    end
  end

  // Pointers and fill count.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (wr)
      begin
        wp_reg <= (wp_reg == AW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (rd)
      begin
        rp_reg <= (rp_reg == AW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(wr) - (AW+1)'(rd);
    end
  end

  // Never more than DEPTH entries.
  a_fifo_bound : assert property (@(posedge clk) disable iff (!rst_b)
    cnt_reg <= (AW+1)'(DEPTH))
    else $error("FIFO count exceeds depth.");

endmodule : silc_fifo

/* File: src/silc_channel.sv */
// Status input logger channel: sampling, time-on accumulation, log timer and triggers.
// Functional notes
// [R1] Status units log a single 0 or 1.
// [R2] Spot mode logs the plain pin level.
// [R3] Inverted spot mode logs the complemented level.
// [R4] Hardware test shows raw level before inversion.
// [R5] Triggers judge logged datapoints, not pin samples.
// [R6] Triggers see the datapoint after inversion.
// [R7] Above zero fires at boundary after rising.
// [R8] Level datapoints never exceed one.
// [R9] Time-on mode logs seconds in state.
// [R10] Accumulate seconds while selected input is one; inverted time-on mode counts seconds at zero.
// [R11] Accumulator clears at each produced datapoint.
// [R12] Channel uses one selected pin only.
// [R13] Two pulse pins, each independently configurable; here both use DEB_CYC and the channel picks one by PIN_SEL.
// [R14] Time-on datapoint never exceeds log period.
// [R15] Pin synchronised, debounced; second tick drives accumulation.
// [R16] Log timer makes the boundary strobe.
module silc_channel #(
  parameter int          SEC_CYC   = silc_pkg::SEC_CYCLES,
  parameter int          DEB_CYC   = silc_pkg::DEB_CYCLES,
  parameter logic [15:0] PERIOD_S  = silc_pkg::LOG_PERIOD_DEF
) (
  // Clock and reset
  input  wire logic                           CLK,
  input  wire logic                           RST_B,
  // Pulse interface pins
  input  wire logic [silc_pkg::NUM_PINS-1:0]  PULSE_IN,
  // Channel configuration
  input  wire logic                           CH_ENABLE,
  input  wire logic                           PIN_SEL,
  input  wire silc_pkg::silc_mode_t           LOG_MODE,
  input  wire logic [silc_pkg::DP_W-1:0]      LOG_PERIOD_S,
  input  wire silc_pkg::silc_trg_cfg_t        TRG_CFG,
  // Status
  output logic      [silc_pkg::NUM_PINS-1:0]  HW_TEST_LEVEL,
  output logic                                TRIG_ACTIVE,
  output logic                                LOG_STROBE,
  // Datapoint stream
  output logic                                DP_VALID,
  input  wire logic                           DP_READY,
  output silc_pkg::silc_dp_t                  DP_DATA,
  output logic                                DP_OVERRUN
);

  localparam int SW = $clog2(SEC_CYC + 1);
  localparam int DW = silc_pkg::DP_W;

  logic [silc_pkg::NUM_PINS-1:0] level;
  logic                          sel_level;
  logic                          inv;
  logic                          log_level;
  logic                          ton_mode;
  logic [SW-1:0]                 sec_cnt_reg;
  logic                          sec_tick;
  logic [DW-1:0]                 per_cnt_reg;
  logic [DW-1:0]                 period;
  logic                          boundary;
  logic [DW-1:0]                 acc_reg;
  logic [DW-1:0]                 dp_value;
  logic [DW-1:0]                 last_dp_reg;
  logic                          hit;
  logic                          fifo_in_ready;
  logic                          fifo_out_valid;
  silc_pkg::silc_dp_t            fifo_out_data;
  silc_pkg::silc_dp_t            dp_next;

  // Each pin has its own filter so the other pin stays free for another use.
  genvar g;
  generate
    for (g = 0; g < silc_pkg::NUM_PINS; g++)
    begin : g_pin
      silc_debounce #(
        .CYCLES (DEB_CYC)
      ) u_deb (
        .clk   (CLK),
        .rst_b (RST_B),
        .din   (PULSE_IN[g]), // [R13]
        .dout  (level[g])     // [R15]
      );
    end
  endgenerate

  // Mode decode; the channel reads only its selected pin.
  assign sel_level = level[PIN_SEL];                  // [R12]
  assign inv       = LOG_MODE[0];
  assign ton_mode  = LOG_MODE[1];
  assign log_level = sel_level ^ inv;                 // [R2] [R3]
  assign period    = (LOG_PERIOD_S == '0) ? PERIOD_S : LOG_PERIOD_S;

  // One-second tick from the clock.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sec_cnt_reg <= '0;
    end
    else if (!CH_ENABLE || sec_tick)
    begin
      sec_cnt_reg <= '0;
    end
    else
    begin
      sec_cnt_reg <= sec_cnt_reg + 1'b1;
    end
  end
  assign sec_tick = CH_ENABLE && (sec_cnt_reg == SW'(SEC_CYC - 1)); // [R15]

  // Log period timer counting seconds to the boundary.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      per_cnt_reg <= '0;
    end
    else if (!CH_ENABLE || boundary)
    begin
      per_cnt_reg <= '0;
    end
    else if (sec_tick)
    begin
      per_cnt_reg <= per_cnt_reg + 1'b1;
    end
  end
  assign boundary = sec_tick && (per_cnt_reg == period - 1'b1); // [R16]

  // Seconds-at-one accumulator, cleared at each datapoint.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      acc_reg <= silc_pkg::DP_RST;
    end
    else if (!CH_ENABLE || boundary)
    begin
      acc_reg <= silc_pkg::DP_RST;                    // [R11]
    end
    else if (sec_tick && log_level)
    begin
      acc_reg <= acc_reg + 1'b1;                      // [R10]
    end
  end

  // Datapoint: last second counts too, so time-on tops out at the period.
  assign dp_value = ton_mode ? (acc_reg + DW'(log_level)) // [R9] [R14]
                             : DW'(log_level);            // [R1] [R8]

  // Trigger comparison on the datapoint as logged.
  always_comb
  begin
    unique case (TRG_CFG.kind)
      silc_pkg::SILC_TRG_OFF:     hit = 1'b0;
      silc_pkg::SILC_TRG_ABOVE:   hit = dp_value > TRG_CFG.thr_a;  // [R6] [R7]
      silc_pkg::SILC_TRG_BELOW:   hit = dp_value < TRG_CFG.thr_a;
      silc_pkg::SILC_TRG_BETWEEN: hit = (dp_value >= TRG_CFG.thr_a) && (dp_value <= TRG_CFG.thr_b);
    endcase
  end

  // Trigger state and last datapoint update only at boundaries; disabling the channel clears the trigger.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      TRIG_ACTIVE <= 1'b0;
      last_dp_reg <= silc_pkg::DP_RST;
    end
    else if (!CH_ENABLE)
    begin
      TRIG_ACTIVE <= 1'b0;
    end
    else if (boundary)
    begin
      TRIG_ACTIVE <= hit;                             // [R5]
      last_dp_reg <= dp_value;
    end
  end

  // Boundary strobe, raw test levels and overrun flag.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      LOG_STROBE    <= 1'b0;
      HW_TEST_LEVEL <= '0;
      DP_OVERRUN    <= 1'b0;
    end
    else
    begin
      LOG_STROBE    <= boundary;
      HW_TEST_LEVEL <= level;                         // [R4]
      DP_OVERRUN    <= boundary && !fifo_in_ready;
    end
  end

  assign dp_next.trig  = hit;
  assign dp_next.value = dp_value;

  // Datapoints queue for the consumer; a full queue drops the new point.
  silc_fifo #(
    .WIDTH ($bits(silc_pkg::silc_dp_t)),
    .DEPTH (silc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (CLK),
    .rst_b     (RST_B),
    .in_valid  (boundary),
    .in_ready  (fifo_in_ready),
    .in_data   (dp_next),
    .out_valid (fifo_out_valid),
    .out_ready (DP_READY && !DP_VALID),
    .out_data  (fifo_out_data)
  );

  // Registered output stage.
  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      DP_VALID <= 1'b0;
      DP_DATA  <= '0;
    end
    else if (DP_VALID)
    begin
      DP_VALID <= !DP_READY;
    end
    else if (fifo_out_valid && DP_READY)
    begin
      DP_VALID <= 1'b1;
      DP_DATA  <= fifo_out_data;
    end
  end

  // Assertions.
  // A log boundary in one of the spot modes.
  sequence s_boundary_spot;
    boundary && !ton_mode;
  endsequence

  // A strobe that stands for one cycle and then drops.
  sequence s_strobe_pulse;
    LOG_STROBE ##1 !LOG_STROBE;
  endsequence

  // A spot datapoint is never above one.
  a_level_range : assert property (@(posedge CLK) disable iff (!RST_B) // [R1]
    s_boundary_spot |-> dp_value <= 16'h0001)
    else $error("Logic-level datapoint above one.");
  // Plain spot mode logs the selected level as it stands.
  a_spot_plain : assert property (@(posedge CLK) disable iff (!RST_B) // [R2]
    (boundary && LOG_MODE == silc_pkg::SILC_SPOT) |-> dp_value[0] == sel_level)
    else $error("Spot datapoint differs from pin level.");
  // Inverted spot mode logs the complement of the selected level.
  a_spot_invert : assert property (@(posedge CLK) disable iff (!RST_B) // [R3]
    (boundary && LOG_MODE == silc_pkg::SILC_SPOT_INV) |-> dp_value[0] != sel_level)
    else $error("Inverted datapoint not complemented.");
  // The test readout is the filtered level of both pins, never inverted.
  a_test_raw : assert property (@(posedge CLK) disable iff (!RST_B) // [R4]
    HW_TEST_LEVEL == $past(level))
    else $error("Hardware test level is not the raw level.");
  // The trigger moves only at a boundary while the channel runs.
  a_trig_boundary : assert property (@(posedge CLK) disable iff (!RST_B) // [R5]
    (CH_ENABLE && $past(CH_ENABLE) && $changed(TRIG_ACTIVE)) |-> $past(boundary))
    else $error("Trigger changed away from a log boundary.");
  // The trigger state follows the datapoint captured at the last boundary.
  a_trig_logged : assert property (@(posedge CLK) disable iff (!RST_B) // [R6]
    ($past(boundary) && TRG_CFG.kind == silc_pkg::SILC_TRG_ABOVE && $stable(TRG_CFG))
    |-> TRIG_ACTIVE == (last_dp_reg > TRG_CFG.thr_a))
    else $error("Trigger does not follow the logged datapoint.");
  // Above zero fires at the boundary that logs a one.
  a_above_zero : assert property (@(posedge CLK) disable iff (!RST_B) // [R7]
    (boundary && !ton_mode && TRG_CFG.kind == silc_pkg::SILC_TRG_ABOVE && TRG_CFG.thr_a == '0
     && log_level) |=> TRIG_ACTIVE)
    else $error("Above-zero trigger missed a logged one.");
  // Above one or more can never fire on a level channel.
  a_above_one : assert property (@(posedge CLK) disable iff (!RST_B) // [R8]
    (boundary && !ton_mode && TRG_CFG.kind == silc_pkg::SILC_TRG_ABOVE && TRG_CFG.thr_a != '0)
    |=> !TRIG_ACTIVE)
    else $error("Above-one trigger fired on a level channel.");
  // The accumulator starts each period from zero.
  a_acc_clear : assert property (@(posedge CLK) disable iff (!RST_B) // [R11]
    boundary |=> acc_reg == '0)
    else $error("Accumulator not cleared after datapoint.");
  // Each second at one adds one to the accumulator.
  a_acc_count : assert property (@(posedge CLK) disable iff (!RST_B) // [R10]
    (sec_tick && !boundary && log_level) |=> acc_reg == $past(acc_reg) + 1'b1)
    else $error("Accumulator missed a second at one.");
  // A time-on datapoint never passes the period length.
  a_ton_bound : assert property (@(posedge CLK) disable iff (!RST_B) // [R9] [R14]
    (boundary && ton_mode) |-> dp_value <= period)
    else $error("Time-on datapoint exceeds log period.");
  // Each boundary gives exactly one strobe pulse.
  a_strobe_follow : assert property (@(posedge CLK) disable iff (!RST_B) // [R16]
    boundary |=> s_strobe_pulse)
    else $error("Log strobe is not a single pulse after boundary.");
  // A boundary that meets a full queue reports the dropped point.
  a_overrun_flag : assert property (@(posedge CLK) disable iff (!RST_B) // [R16]
    (boundary && !fifo_in_ready) |=> DP_OVERRUN)
    else $error("Dropped datapoint not reported.");
  // The seconds counter restarts after every tick.
  a_tick_clear : assert property (@(posedge CLK) disable iff (!RST_B) // [R15]
    sec_tick |=> sec_cnt_reg == '0)
    else $error("Seconds counter did not restart after a tick.");

endmodule : silc_channel

/* File: verification/silc_switch_model.sv */
// Open/closed switch contact model that drives both pulse pins.
module silc_switch_model
(
  // Clock
  input  wire logic       clk,
  // Commanded contact state and one-cycle spikes
  input  wire logic [1:0] closed,
  input  wire logic [1:0] spike,
  // Pin levels seen by the channel
  output logic      [1:0] contact
);
  timeunit 1ns;
  timeprecision 100ps;

  // The contact starts open so that the pins are never unknown.
  initial contact = 2'h0;

  // A spike flips a pin for one cycle, which is shorter than the debounce time.
  always @(posedge clk)
  begin
    contact <= #3 closed ^ spike;
  end
endmodule : silc_switch_model

/* File: verification/testbench.sv */
// Self-checking testbench for the status input logger channel.
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int          SEC   = 20;
  localparam logic [15:0] PER   = 16'h0003;
  localparam int          CM[6] = '{0, 1, 0, 2, 3, 2};
  localparam int          CK[6] = '{3, 3, 3, 3, 1, 0};
  localparam int          CT[6] = '{1, 1, 1, 3, 2, 1};
  localparam int          CA[6] = '{0, 0, 1, 3, 3, 0};

  logic                    CLK;
  logic                    RST_B;
  logic                    CH_ENABLE;
  logic                    PIN_SEL;
  logic                    DP_READY;
  logic [1:0]              closed;
  logic [1:0]              spike;
  logic [1:0]              pins;
  logic [15:0]             per_s;
  logic [1:0]              hw;
  logic                    trig_act;
  logic                    strobe;
  logic                    dp_valid;
  logic                    overrun;
  silc_pkg::silc_mode_t    mode;
  silc_pkg::silc_trg_cfg_t trg;
  silc_pkg::silc_trg_cfg_t rt;
  silc_pkg::silc_dp_t      dp;
  silc_pkg::silc_dp_t      exp_dp[$];
  int                      n_mismatch;
  int                      n_compared;

  silc_switch_model silc_switch_model_inst (.clk(CLK), .closed(closed), .spike(spike), .contact(pins));

  silc_channel #(.SEC_CYC(SEC), .DEB_CYC(2), .PERIOD_S(PER)) silc_channel_inst (
    .CLK(CLK), .RST_B(RST_B), .PULSE_IN(pins), .CH_ENABLE(CH_ENABLE), .PIN_SEL(PIN_SEL),
    .LOG_MODE(mode), .LOG_PERIOD_S(per_s), .TRG_CFG(trg), .HW_TEST_LEVEL(hw), .TRIG_ACTIVE(trig_act),
    .LOG_STROBE(strobe), .DP_VALID(dp_valid), .DP_READY(DP_READY), .DP_DATA(dp), .DP_OVERRUN(overrun));

  // The clock runs at 25 MHz.
  initial
  begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end

  // Trigger outcome worked out from the logged value.
  function automatic logic trig_of(silc_pkg::silc_trg_cfg_t c, logic [15:0] v);
    case (c.kind)
      silc_pkg::SILC_TRG_ABOVE:   return v > c.thr_a;
      silc_pkg::SILC_TRG_BELOW:   return v < c.thr_a;
      silc_pkg::SILC_TRG_BETWEEN: return v >= c.thr_a && v <= c.thr_b;
      default:                    return 1'b0;
    endcase
  endfunction : trig_of

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // Every accepted datapoint must equal the oldest expected one, in order.
  always @(posedge CLK)
  begin
    if (dp_valid === 1'b1 && DP_READY === 1'b1)
    begin
      `CHK(exp_dp.size() > 0, 1'b1)
      if (exp_dp.size() > 0)
      begin
        `CHK(dp, exp_dp[0])
        void'(exp_dp.pop_front());
      end
    end
  end

  // Waits, bounded, for the cycle in which the boundary strobe shows.
  task automatic wait_strobe();
    bit seen;
    int i;
    seen = 1'b0;
    for (i = 0; i < 200 && !seen; i++)
    begin
      @(posedge CLK);
      #1;
      seen = (strobe === 1'b1);
    end
    `CHK(seen, 1'b1)
  endtask : wait_strobe

  // Checks the trigger and overrun at a boundary and queues the datapoint unless the buffer is full.
  task automatic at_boundary(input logic [15:0] v);
    silc_pkg::silc_dp_t e;
    e = {trig_of(trg, v), v};
    `CHK(trig_act, e.trig)
    `CHK(overrun, exp_dp.size() >= silc_pkg::FIFO_DEPTH)
    if (exp_dp.size() < silc_pkg::FIFO_DEPTH)
      exp_dp.push_back(e);
  endtask : at_boundary

  // One log period: the selected pin is closed for the first k seconds; k of 3 means all period.
  task automatic period(input silc_pkg::silc_mode_t m, input int k, input silc_pkg::silc_trg_cfg_t t, input bit rdy);
    logic [15:0] v;
    mode = m;
    trg = t;
    PIN_SEL = 1'($urandom);
    closed[PIN_SEL] = (k > 0);
    closed[~PIN_SEL] = 1'($urandom);
    repeat (9) @(posedge CLK);
    #1;
    `CHK(hw, closed)
    DP_READY = rdy;
    spike = 2'($urandom);
    @(posedge CLK);
    #1;
    spike = 2'h0;
    repeat (6) @(posedge CLK);
    #1;
    `CHK(hw, closed)
    if (k < 3)
    begin
      repeat (SEC * k - 8) @(posedge CLK);
      #1;
      closed[PIN_SEL] = 1'b0;
    end
    v = m[1] ? (m[0] ? PER - 16'(k) : 16'(k)) : {15'h0, (k == 3) ^ m[0]};
    wait_strobe();
    at_boundary(v);
  endtask : period

  // Watchdog that cuts a hang short.
  initial
  begin
    repeat (20000) @(posedge CLK);
    n_mismatch++;
    close_out();
  end

  // Main sequence.
  initial
  begin
    n_mismatch = 0;
    n_compared = 0;
    RST_B = 1'b0;
    CH_ENABLE = 1'b1;
    PIN_SEL = 1'b0;
    DP_READY = 1'b1;
    per_s = PER;
    closed = 2'h0;
    spike = 2'h0;
    mode = silc_pkg::SILC_SPOT;
    trg = '0;
    void'($urandom(32));
    repeat (5) @(posedge CLK);
    #1;
    RST_B = 1'b1;
    wait_strobe();
    at_boundary(16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      rt = '{silc_pkg::silc_trg_t'(CT[i]), 16'(CA[i]), PER};
      period(silc_pkg::silc_mode_t'(CM[i]), CK[i], rt, 1'b1);
    end
    $display("test corner done");
    // The last period arms an above-zero trigger, so that disabling has something to clear.
    for (int i = 0; i < 6; i++)
    begin
      rt = '{silc_pkg::silc_trg_t'(i == 5), 16'h0000, PER};
      period(silc_pkg::SILC_SPOT, 3 * (i % 2), rt, i == 5);
    end
    $display("test overrun done");
    mode = silc_pkg::SILC_TON;
    trg = '{silc_pkg::SILC_TRG_ABOVE, 16'h0002, PER};
    closed[PIN_SEL] = 1'b1;
    repeat (30) @(posedge CLK);
    #1;
    CH_ENABLE = 1'b0;
    repeat (2) @(posedge CLK);
    #1;
    `CHK(trig_act, 1'b0)
    CH_ENABLE = 1'b1;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge CLK);
      #1;
      `CHK(strobe, 1'b0)
    end
    wait_strobe();
    at_boundary(PER);
    $display("test enable done");
    for (int i = 0; i < 20; i++)
    begin
      // Zero selects the default period, which the instance sets equal to PER.
      per_s = (i % 2 == 0) ? PER : 16'h0000;
      rt = '{silc_pkg::silc_trg_t'(2'($urandom)), 16'($urandom % 5), 16'($urandom % 5)};
      period(silc_pkg::silc_mode_t'(2'($urandom)), $urandom % 4, rt, 1'b1);
    end
    repeat (10) @(posedge CLK);
    `CHK(exp_dp.size(), 0)
    $display("test random done");
    close_out();
  end
endmodule : testbench
